// ==== logic/tsc_config_control.sv ====
// Configuration registers, conversion sequencer and alarm pin control of the temperature monitor.
`timescale 1ns/100ps
module tsc_config_control
#(
    parameter int MS_CYCLES = tsc_pkg::MS_CYCLES_DEF
) (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    input  wire logic [7:0]  I_REG_PTR,
    input  wire logic [7:0]  I_REG_WDATA,
    output logic      [7:0]  O_REG_RDATA,
    input  wire logic        I_ALERT_ACK,
    input  wire logic        I_CONV_DONE,
    input  wire logic [8:0]  I_CONV_TEMP,
    input  wire logic        I_DIODE_OPEN,
    input  wire logic [7:0]  I_LOCAL_HIGH_LIM,
    input  wire logic [7:0]  I_LOCAL_LOW_LIM,
    input  wire logic [7:0]  I_REMOTE_HIGH_LIM,
    input  wire logic [7:0]  I_REMOTE_LOW_LIM,
    input  wire logic [7:0]  I_HYST,
    input  wire logic [1:0]  I_CONSEC_SEL,
    input  wire logic [7:0]  I_RATE_CODE,
    output logic             O_CONV_START,
    output logic             O_CONV_REMOTE,
    output logic             O_RES_CORR,
    output logic             O_BUSY,
    output logic      [7:0]  O_LOCAL_RESULT,
    output logic      [7:0]  O_REMOTE_RESULT,
    output logic             O_ALARM_PIN_O,
    output logic             O_ALARM_PIN_OE
);
    import tsc_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        seq_state_t state;
        logic       oneshot;
        logic       conv_start;
        logic       conv_remote;
        logic       busy;
        logic       rate_start;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] rdata;
        logic [7:0] local_res;
        logic [7:0] remote_res;
        logic       local_smp;
        logic       remote_smp;
        logic       open_cond;
        logic       local_high_flag;
        logic       llow;
        logic       remote_high_flag;
        logic       rlow;
        logic       open;
        logic       alert;
        logic       pin_oe;
    } core_t;

    core_t      s_r;
    core_t      s_nxt;
    logic       l_hi_f;
    logic       l_lo_f;
    logic       l_therm;
    logic       r_hi_f;
    logic       r_lo_f;
    logic       r_therm;
    logic       rate_done;
    logic       wr_cfg1;
    logic       wr_cfg2;
    logic       wr_oneshot;
    logic       stat_rd;
    logic       halt;
    logic       pinf;
    logic       len;
    logic       ren;
    logic       run_on;
    logic [4:0] src_old;
    logic [4:0] src_new;
    logic [7:0] status;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Clamps a signed reading into the selected stored format.
    function automatic logic [7:0] fmt_temp(input logic [8:0] t, input logic ext);
        logic signed [9:0] v;
        logic signed [9:0] top;
        v   = $signed({t[8], t});
        top = ext ? EXT_MAX : STD_MAX;
        if (ext) begin
            v = v + EXT_OFFSET;
        end
        if (v < 10'sh000) begin
            return 8'h00;
        end else if (v > top) begin
            return top[7:0];
        end
        return v[7:0];
    endfunction

    // ----------------------------------------------------------------
    // Channel checks and rate delay
    // ----------------------------------------------------------------
    tsc_limit_check u_local_chk (
        .i_clk        (I_CORE_CLK),
        .i_rst_n      (I_RST_N),
        .i_sample     (s_r.local_smp),
        .i_temp       (s_r.local_res),
        .i_high       (I_LOCAL_HIGH_LIM),
        .i_low        (I_LOCAL_LOW_LIM),
        .i_hyst       (I_HYST),
        .i_consec     (I_CONSEC_SEL),
        .o_high_fault (l_hi_f),
        .o_low_fault  (l_lo_f),
        .o_therm_high (l_therm)
    );

    tsc_limit_check u_remote_chk (
        .i_clk        (I_CORE_CLK),
        .i_rst_n      (I_RST_N),
        .i_sample     (s_r.remote_smp),
        .i_temp       (s_r.remote_res),
        .i_high       (I_REMOTE_HIGH_LIM),
        .i_low        (I_REMOTE_LOW_LIM),
        .i_hyst       (I_HYST),
        .i_consec     (I_CONSEC_SEL),
        .o_high_fault (r_hi_f),
        .o_low_fault  (r_lo_f),
        .o_therm_high (r_therm)
    );

    tsc_rate_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_rate (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_start (s_r.rate_start),
        .i_code  (I_RATE_CODE),
        .o_done  (rate_done)
    );

    // ----------------------------------------------------------------
    // Register access decode
    // ----------------------------------------------------------------
    always_comb begin
        wr_cfg1    = I_REG_WR && (I_REG_PTR == PTR_CFG1_WR);
        wr_cfg2    = I_REG_WR && (I_REG_PTR == PTR_CFG2);
        wr_oneshot = I_REG_WR && (I_REG_PTR == PTR_ONE_SHOT);
        stat_rd    = I_REG_RD && (I_REG_PTR == PTR_STATUS);
    end

    assign halt   = s_r.cfg1[CFG1_HALT_BIT];
    assign pinf   = s_r.cfg1[CFG1_PINF_BIT];
    assign len    = s_r.cfg2[CFG2_LEN_BIT];
    assign ren    = s_r.cfg2[CFG2_REN_BIT];
    assign run_on = !halt || s_r.oneshot;
    assign status = {s_r.busy, s_r.local_high_flag, s_r.llow, s_r.remote_high_flag, s_r.rlow, s_r.open, 2'b00};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt            = s_r;
        s_nxt.conv_start = 1'b0;
        s_nxt.rate_start = 1'b0;
        s_nxt.local_smp  = 1'b0;
        s_nxt.remote_smp = 1'b0;
        src_old          = '0;
        src_new          = '0;

        // Reserved bits are dropped so a careless host cannot park state in them.
        if (wr_cfg1) begin
            s_nxt.cfg1 = I_REG_WDATA & CFG1_WMASK;
        end
        if (wr_cfg2) begin
            s_nxt.cfg2 = I_REG_WDATA & CFG2_WMASK;
        end
        if (I_REG_RD) begin
            if (I_REG_PTR == PTR_STATUS) begin
                s_nxt.rdata = status;
            end else if (I_REG_PTR == PTR_CFG1_RD) begin
                s_nxt.rdata = s_r.cfg1;
            end else if (I_REG_PTR == PTR_CFG2) begin
                s_nxt.rdata = s_r.cfg2;
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end
        // A one-shot request only counts while the sequencer sits in shutdown.
        if (wr_oneshot && halt && (s_r.state == SEQ_HALT)) begin
            s_nxt.oneshot = 1'b1;
        end

        // Conversion sequencer.
        case (s_r.state)
            SEQ_HALT: begin
                if (!halt || s_nxt.oneshot) begin
                    if (len) begin
                        s_nxt.state = SEQ_LOCAL;
                    end else if (ren) begin
                        s_nxt.state = SEQ_REMOTE;
                    end else if (s_nxt.oneshot) begin
                        s_nxt.oneshot = 1'b0;
                    end else begin
                        s_nxt.state = SEQ_WAIT;
                        s_nxt.rate_start = 1'b1;
                    end
                end
            end
            SEQ_LOCAL: begin
                if (I_CONV_DONE) begin
                    s_nxt.local_res = fmt_temp(I_CONV_TEMP, s_r.cfg1[CFG1_RANGE_BIT]);
                    s_nxt.local_smp = 1'b1;
                    if (ren) begin
                        s_nxt.state = SEQ_REMOTE;
                    end else if (s_r.oneshot) begin
                        s_nxt.state   = SEQ_HALT;
                        s_nxt.oneshot = 1'b0;
                    end else begin
                        s_nxt.state      = SEQ_WAIT;
                        s_nxt.rate_start = 1'b1;
                    end
                end
            end
            SEQ_REMOTE: begin
                if (I_CONV_DONE) begin
                    s_nxt.remote_res = fmt_temp(I_CONV_TEMP, s_r.cfg1[CFG1_RANGE_BIT]);
                    s_nxt.remote_smp = 1'b1;
                    s_nxt.open_cond  = I_DIODE_OPEN;
                    if (s_r.oneshot) begin
                        s_nxt.state   = SEQ_HALT;
                        s_nxt.oneshot = 1'b0;
                    end else begin
                        s_nxt.state      = SEQ_WAIT;
                        s_nxt.rate_start = 1'b1;
                    end
                end
            end
            SEQ_WAIT: begin
                if (rate_done) begin
                    if (len) begin
                        s_nxt.state = SEQ_LOCAL;
                    end else if (ren) begin
                        s_nxt.state = SEQ_REMOTE;
                    end else begin
                        s_nxt.rate_start = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.state = SEQ_HALT;
            end
        endcase

        // Shutdown cuts off any conversion or delay in progress, other than a one-shot, on the next edge.
        if (halt && !s_r.oneshot && (s_r.state != SEQ_HALT)) begin
            s_nxt.state      = SEQ_HALT;
            s_nxt.rate_start = 1'b0;
            s_nxt.local_smp  = 1'b0;
            s_nxt.remote_smp = 1'b0;
        end
        if (!run_on) begin
            s_nxt.oneshot = s_nxt.oneshot && (s_r.state == SEQ_HALT);
        end
        if ((s_nxt.state == SEQ_LOCAL || s_nxt.state == SEQ_REMOTE) && (s_nxt.state != s_r.state)) begin
            s_nxt.conv_start  = 1'b1;
            s_nxt.conv_remote = (s_nxt.state == SEQ_REMOTE);
        end
        s_nxt.busy = (s_nxt.state == SEQ_LOCAL) || (s_nxt.state == SEQ_REMOTE);

        // Status flags: a new event in the clearing cycle keeps the flag set.
        s_nxt.llow = (s_r.llow && !(stat_rd && !l_lo_f)) || l_lo_f;
        s_nxt.rlow = (s_r.rlow && !(stat_rd && !r_lo_f)) || r_lo_f;
        s_nxt.open = (s_r.open && !(stat_rd && !s_r.open_cond)) || s_r.open_cond;
        if (s_nxt.cfg1[CFG1_PINF_BIT]) begin
            s_nxt.local_high_flag = l_therm;
            s_nxt.remote_high_flag = r_therm;
        end else begin
            s_nxt.local_high_flag = (s_r.local_high_flag && !(stat_rd && !l_hi_f)) || l_hi_f;
            s_nxt.remote_high_flag = (s_r.remote_high_flag && !(stat_rd && !r_hi_f)) || r_hi_f;
        end

        // The alarm latch follows any latched flag rising in alert mode; only the
        // acknowledge clears it, so reading status leaves the pin as it is.
        src_old = {s_r.local_high_flag, s_r.remote_high_flag, s_r.llow, s_r.rlow, s_r.open};
        src_new = {s_nxt.local_high_flag, s_nxt.remote_high_flag, s_nxt.llow, s_nxt.rlow, s_nxt.open};
        if (!pinf && !s_nxt.cfg1[CFG1_PINF_BIT]) begin
            s_nxt.alert = (s_r.alert && !I_ALERT_ACK) || |(src_new & ~src_old);
        end else begin
            s_nxt.alert = s_r.alert && !I_ALERT_ACK;
        end

        // Pin drive: thermal mode ignores the mask entirely.
        if (s_nxt.cfg1[CFG1_PINF_BIT]) begin
            s_nxt.pin_oe = s_nxt.local_high_flag || s_nxt.remote_high_flag;
        end else begin
            s_nxt.pin_oe = s_nxt.alert && !s_nxt.cfg1[CFG1_MASK_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            s_r            <= '0;
            s_r.state      <= SEQ_HALT;
            s_r.cfg1       <= CFG1_RESET;
            s_r.cfg2       <= CFG2_RESET;
            s_r.rdata      <= RDATA_RESET;
            s_r.local_res  <= RESULT_RESET;
            s_r.remote_res <= RESULT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign O_REG_RDATA     = s_r.rdata;
    assign O_CONV_START    = s_r.conv_start;
    assign O_CONV_REMOTE   = s_r.conv_remote;
    assign O_RES_CORR      = s_r.cfg2[CFG2_RC_BIT];
    assign O_BUSY          = s_r.busy;
    assign O_LOCAL_RESULT  = s_r.local_res;
    assign O_REMOTE_RESULT = s_r.remote_res;
    // The pin is open drain: it only ever pulls low.
    assign O_ALARM_PIN_O   = 1'b0;
    assign O_ALARM_PIN_OE  = s_r.pin_oe;
endmodule

// ==== logic/tsc_pkg.sv ====
// Shared constants and types for the temperature sensor configuration and control block.
package tsc_pkg;
    // ----------------------------------------------------------------
    // Pointer addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] PTR_STATUS   = 8'h02;
    localparam logic [7:0] PTR_CFG1_RD  = 8'h03;
    localparam logic [7:0] PTR_CFG1_WR  = 8'h09;
    localparam logic [7:0] PTR_ONE_SHOT = 8'h0f;
    localparam logic [7:0] PTR_CFG2     = 8'h1a;
    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int         CFG1_MASK_BIT  = 7;
    localparam int         CFG1_HALT_BIT  = 6;
    localparam int         CFG1_PINF_BIT  = 5;
    localparam int         CFG1_RANGE_BIT = 2;
    localparam logic [7:0] CFG1_WMASK     = 8'he4;
    localparam logic [7:0] CFG1_RESET     = 8'h00;
    localparam int         CFG2_REN_BIT   = 4;
    localparam int         CFG2_LEN_BIT   = 3;
    localparam int         CFG2_RC_BIT    = 2;
    localparam logic [7:0] CFG2_WMASK     = 8'h1c;
    localparam logic [7:0] CFG2_RESET     = 8'h1c;
    localparam logic [7:0] RDATA_RESET    = 8'h00;
    localparam logic [7:0] RESULT_RESET   = 8'h00;
    // ----------------------------------------------------------------
    // Result formats
    // ----------------------------------------------------------------
    localparam logic signed [9:0] EXT_OFFSET = 10'sh040;
    localparam logic signed [9:0] STD_MAX    = 10'sh07f;
    localparam logic signed [9:0] EXT_MAX    = 10'sh0ff;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 50;
    localparam int         MS_TIME_US      = 1000;
    localparam int         MS_CYCLES_DEF   = (MS_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam logic [13:0] RATE_SLOWEST_MS = 14'h3e80;
    localparam logic [2:0] RATE_CODE_MAX   = 3'h7;
    // ----------------------------------------------------------------
    // Conversion sequence states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_HALT   = 2'b00,
        SEQ_LOCAL  = 2'b01,
        SEQ_REMOTE = 2'b10,
        SEQ_WAIT   = 2'b11
    } seq_state_t;
endpackage

// ==== logic/tsc_limit_check.sv ====
// Per-channel limit comparison with consecutive-count filter and hysteresis.
`timescale 1ns/100ps
module tsc_limit_check (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sample,
    input  wire logic [7:0] i_temp,
    input  wire logic [7:0] i_high,
    input  wire logic [7:0] i_low,
    input  wire logic [7:0] i_hyst,
    input  wire logic [1:0] i_consec,
    output logic            o_high_fault,
    output logic            o_low_fault,
    output logic            o_therm_high
);
    typedef struct packed {
        logic [2:0] hi_cnt;
        logic [2:0] lo_cnt;
        logic       hi_f;
        logic       lo_f;
        logic       therm;
    } chk_t;

    chk_t       s_r;
    chk_t       s_nxt;
    logic [8:0] thr;
    logic [2:0] hi_n;
    logic [2:0] lo_n;

    always_comb begin
        s_nxt = s_r;
        thr   = {1'b0, i_high} - {1'b0, i_hyst};
        hi_n  = (s_r.hi_cnt == 3'h4) ? 3'h4 : s_r.hi_cnt + 3'h1;
        lo_n  = (s_r.lo_cnt == 3'h4) ? 3'h4 : s_r.lo_cnt + 3'h1;
        if (i_sample) begin
            s_nxt.hi_cnt = (i_temp > i_high) ? hi_n : 3'h0;
            s_nxt.lo_cnt = (i_temp < i_low) ? lo_n : 3'h0;
            s_nxt.hi_f   = (i_temp > i_high) && (hi_n > {1'b0, i_consec});
            s_nxt.lo_f   = (i_temp < i_low) && (lo_n > {1'b0, i_consec});
            // An underflowed threshold can never be crossed downward, so the flag holds.
            if (i_temp > i_high) begin
                s_nxt.therm = 1'b1;
            end else if (!thr[8] && (i_temp < thr[7:0])) begin
                s_nxt.therm = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_high_fault = s_r.hi_f;
    assign o_low_fault  = s_r.lo_f;
    assign o_therm_high = s_r.therm;
endmodule

// ==== logic/tsc_rate_timer.sv ====
// Rate delay timer: a millisecond enable divider and a delay counter.
`timescale 1ns/100ps
module tsc_rate_timer
    import tsc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_start,
    input  wire logic [7:0] i_code,
    output logic            o_done
);
    localparam int DW = $clog2(MS_CYCLES);
    localparam logic [DW-1:0] DIV_LAST = DW'(MS_CYCLES - 1);

    typedef struct packed {
        logic [DW-1:0] div;
        logic [13:0]   ms_left;
        logic          run;
        logic          done;
    } tmr_t;

    tmr_t       s_r;
    tmr_t       s_nxt;
    logic [2:0] code;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        // Codes above the fastest setting behave as the fastest setting.
        code = (i_code > {5'h00, RATE_CODE_MAX}) ? RATE_CODE_MAX : i_code[2:0];
        if (i_start) begin
            s_nxt.run     = 1'b1;
            s_nxt.div     = '0;
            s_nxt.ms_left = RATE_SLOWEST_MS >> code;
        end else if (s_r.run) begin
            if (s_r.div == DIV_LAST) begin
                s_nxt.div = '0;
                if (s_r.ms_left == 14'h0001) begin
                    s_nxt.run  = 1'b0;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.ms_left = s_r.ms_left - 14'h0001;
                end
            end else begin
                s_nxt.div = s_r.div + DW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_done = s_r.done;
endmodule

// ==== dv/tsc_properties.sv ====
// Port-level checker of the configuration and control block, bound into its top module.
`timescale 1ns/100ps
module tsc_properties (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RST_N,
    input wire logic       I_REG_WR,
    input wire logic       I_REG_RD,
    input wire logic [7:0] I_REG_PTR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic       O_CONV_START,
    input wire logic       O_CONV_REMOTE,
    input wire logic       O_RES_CORR,
    input wire logic       O_BUSY,
    input wire logic       O_ALARM_PIN_O,
    input wire logic       O_ALARM_PIN_OE
);
    import tsc_pkg::*;
    logic [7:0] c1;
    logic [7:0] c2;
    // Shadow copies of both configuration registers, built only from bus writes.
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            c1 <= CFG1_RESET;
            c2 <= CFG2_RESET;
        end else if (I_REG_WR) begin
            if (I_REG_PTR == PTR_CFG1_WR) c1 <= I_REG_WDATA & CFG1_WMASK;
            if (I_REG_PTR == PTR_CFG2) c2 <= I_REG_WDATA & CFG2_WMASK;
        end
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    AST_PIN_LOW: assert property (O_ALARM_PIN_O == 1'b0) else $error("alarm drive level high");
    AST_START: assert property (O_CONV_START |-> O_BUSY ##1 !O_CONV_START) else $error("bad start");
    AST_HALT: assert property (I_REG_WR && I_REG_PTR == PTR_CFG1_WR && I_REG_WDATA[6] |-> ##[2:4] !O_BUSY)
        else $error("busy after halt");
    AST_RES: assert property (I_REG_WR && I_REG_PTR == PTR_CFG2 |-> ##2 O_RES_CORR == $past(I_REG_WDATA[2], 2))
        else $error("correction level");
    AST_RD1: assert property (I_REG_RD && I_REG_PTR == PTR_CFG1_RD |-> ##2 O_REG_RDATA == $past(c1, 2))
        else $error("first register read");
    AST_RD2: assert property (I_REG_RD && I_REG_PTR == PTR_CFG2 |-> ##2 O_REG_RDATA == $past(c2, 2))
        else $error("second register read");
    AST_RDWO: assert property (I_REG_RD && I_REG_PTR == PTR_CFG1_WR |-> ##2 O_REG_RDATA == 8'h00)
        else $error("write pointer read");
    AST_MASK: assert property (c1[7] && !c1[5] && $past(c1[7] && !c1[5]) |-> !O_ALARM_PIN_OE)
        else $error("masked alarm pulled");
    AST_LOCOFF: assert property (O_CONV_START && !c2[3] && !$past(c2[3], 2) |-> O_CONV_REMOTE)
        else $error("local channel not skipped");
    AST_REMOFF: assert property (O_CONV_START && !c2[4] && !$past(c2[4], 2) |-> !O_CONV_REMOTE)
        else $error("remote channel not skipped");
    cover property (O_CONV_START && O_CONV_REMOTE);
    cover property ($rose(O_ALARM_PIN_OE));
    cover property (I_REG_WR && I_REG_PTR == PTR_ONE_SHOT);
endmodule
bind tsc_config_control tsc_properties i_props (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_PTR(I_REG_PTR), .I_REG_WDATA(I_REG_WDATA),
    .O_REG_RDATA(O_REG_RDATA), .O_CONV_START(O_CONV_START), .O_CONV_REMOTE(O_CONV_REMOTE),
    .O_RES_CORR(O_RES_CORR), .O_BUSY(O_BUSY), .O_ALARM_PIN_O(O_ALARM_PIN_O), .O_ALARM_PIN_OE(O_ALARM_PIN_OE));

// ==== dv/tsc_conv_model.sv ====
// Behavioural converter that answers each conversion start after a fixed time.
`timescale 1ns/100ps
module tsc_conv_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_start,
    input  wire logic       i_remote,
    input  wire logic [8:0] i_ltemp,
    input  wire logic [8:0] i_rtemp,
    output logic            o_done = 1'b0,
    output logic      [8:0] o_temp = 9'h000
);
    logic [3:0] cnt_r = 4'h0;
    logic [8:0] t;
    assign t = i_remote ? i_rtemp : i_ltemp;
    always @(posedge i_clk) begin
        if (!i_rst_n) cnt_r <= 4'h0;
        else if (i_start) cnt_r <= 4'h6;
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        o_done <= (cnt_r == 4'h1);
        // Outside the done pulse the reading is inverted so a stale value never passes for a fresh one.
        o_temp <= (cnt_r == 4'h1) ? t : ~t;
    end
endmodule

// ==== dv/test_tsc_config_control.sv ====
// Self-checking bench of the configuration and control block.
`timescale 1ns/100ps
module test_tsc_config_control;
    import tsc_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0;
    logic [7:0] ptr = 8'h00, wd = 8'h00, lim = 8'h50, hyst = 8'h0a, rdata, lres, rres;
    logic [8:0] lt = 9'h01e, rt = 9'h064, temp;
    logic [1:0] cs = 2'h0;
    logic       done, start, rem, corr, busy, oe;
    int         n_mismatch = 0, n_checks = 0, n_start = 0, n_rem = 0, cyc = 0, s0, r0;
    always #25 clk = ~clk;
    tsc_config_control #(.MS_CYCLES(4)) i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_PTR(ptr), .I_REG_WDATA(wd), .O_REG_RDATA(rdata), .I_ALERT_ACK(ack),
        .I_CONV_DONE(done), .I_CONV_TEMP(temp), .I_DIODE_OPEN(1'b0), .I_LOCAL_HIGH_LIM(lim),
        .I_LOCAL_LOW_LIM(8'h00), .I_REMOTE_HIGH_LIM(lim), .I_REMOTE_LOW_LIM(8'h00), .I_HYST(hyst),
        .I_CONSEC_SEL(cs), .I_RATE_CODE(8'h07), .O_CONV_START(start), .O_CONV_REMOTE(rem),
        .O_RES_CORR(corr), .O_BUSY(busy), .O_LOCAL_RESULT(lres), .O_REMOTE_RESULT(rres),
        .O_ALARM_PIN_O(), .O_ALARM_PIN_OE(oe));
    tsc_conv_model i_conv (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_remote(rem),
        .i_ltemp(lt), .i_rtemp(rt), .o_done(done), .o_temp(temp));
    // ----------------------------------------------------------------
    // Monitor, timeout and shared tasks
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (start) n_start++;
        if (start && rem) n_rem++;
        if (cyc == 6000) begin
            n_mismatch++;
            close_out;
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrr(input logic [7:0] p, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ptr <= p;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        ptr <= p;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
        chk("rdata", e, rdata);
    endtask
    // The window of 40 cycles covers both channels plus the limit path to the alarm pin.
    task automatic shot;
        #1;
        s0 = n_start;
        r0 = n_rem;
        wrr(PTR_ONE_SHOT, 8'h00);
        repeat (40) @(posedge clk);
        #1;
    endtask
    task automatic t_regs;
        rdc(PTR_CFG1_RD, 8'h00);
        rdc(PTR_CFG2, 8'h1c);
        chk("corr", 8'h01, {7'h00, corr});
        wrr(PTR_CFG1_WR, 8'he4);
        rdc(PTR_CFG1_RD, 8'he4);
        wrr(PTR_CFG1_RD, 8'h00);
        rdc(PTR_CFG1_RD, 8'he4);
        rdc(PTR_CFG1_WR, 8'h00);
        wrr(PTR_CFG2, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk("corr", 8'h00, {7'h00, corr});
        rdc(PTR_CFG2, 8'h00);
        wrr(PTR_CFG2, 8'h1c);
    endtask
    task automatic t_halt;
        wrr(PTR_CFG1_WR, 8'h40);
        repeat (4) @(posedge clk);
        #1;
        chk("busy", 8'h00, {7'h00, busy});
        s0 = n_start;
        repeat (600) @(posedge clk);
        chk("halted starts", 8'h00, 8'(n_start - s0));
        shot;
        chk("shot starts", 8'h02, 8'(n_start - s0));
        chk("shot remote", 8'h01, 8'(n_rem - r0));
        wrr(PTR_CFG1_WR, 8'h00);
        #1;
        s0 = n_start;
        repeat (700) @(posedge clk);
        chk("run starts", 8'h01, 8'(n_start - s0 >= 3));
    endtask
    task automatic t_chan;
        wrr(PTR_CFG1_WR, 8'h40);
        wrr(PTR_CFG2, 8'h14);
        shot;
        chk("remote only", 8'h01, 8'(n_start - s0));
        chk("remote only rem", 8'h01, 8'(n_rem - r0));
        wrr(PTR_CFG2, 8'h0c);
        shot;
        chk("local only", 8'h01, 8'(n_start - s0));
        chk("local only rem", 8'h00, 8'(n_rem - r0));
        wrr(PTR_CFG2, 8'h1c);
    endtask
    task automatic t_alarm;
        // Earlier scenarios leave the remote flag and the alarm latched; clear both first.
        rt = 9'h03c;
        shot;
        rdc(PTR_STATUS, 8'h10);
        @(posedge clk);
        ack <= 1'b1;
        cs <= 2'h1;
        @(posedge clk);
        ack <= 1'b0;
        rt = 9'h064;
        shot;
        chk("one of two", 8'h00, {7'h00, oe});
        shot;
        chk("alert pin", 8'h01, {7'h00, oe});
        wrr(PTR_CFG1_WR, 8'hc0);
        repeat (3) @(posedge clk);
        #1;
        chk("masked pin", 8'h00, {7'h00, oe});
        wrr(PTR_CFG1_WR, 8'he0);
        shot;
        chk("thermal pin", 8'h01, {7'h00, oe});
        rt = 9'h03c;
        shot;
        chk("thermal release", 8'h00, {7'h00, oe});
        wrr(PTR_CFG1_WR, 8'h40);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("acked pin", 8'h00, {7'h00, oe});
    endtask
    task automatic t_range;
        rt = 9'h0c8;
        shot;
        chk("std local", 8'h1e, lres);
        chk("std remote", STD_MAX[7:0], rres);
        wrr(PTR_CFG1_WR, 8'h44);
        shot;
        chk("ext local", 8'h5e, lres);
        chk("ext remote", EXT_MAX[7:0], rres);
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_halt;
        t_chan;
        t_alarm;
        t_range;
        close_out;
    end
endmodule
